// *** include/config_port_regs.vh ***
// Constants for the configuration port and status pin block.
`ifndef CONFIG_PORT_REGS_VH
`define CONFIG_PORT_REGS_VH
// Master-mode extra wait after the init line rises, in nanoseconds.
`define WAIT_MIN_NS      30000
`define WAIT_MAX_NS      300000
`define CLK_PERIOD_NS    4
// Least wait rounds up to whole cycles.
`define WAIT_CYCLES      ((`WAIT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Memory clear length in cycles (plain default).
`define CLEAR_CYCLES     64
// Mode encodings of mode_select_pins.
`define MODE_SLAVE_SER   3'h7
`define MODE_MASTER_SER  3'h0
`define MODE_MASTER_PAR  3'h6
`define MODE_PERIPH_ASY  3'h5
`define MODE_DAISY       3'h3
// Status read-back byte: bit 7 status, bits 6..0 high.
`define STATUS_FILL      7'h7f
`define ADDR_WIDTH       18
`define ADDR_EXT_WIDTH   4
`define ADDR_START       22'h000000
// Register bus offsets (interrupt block).
`define REG_STATUS       4'h0
`define REG_CLEAR        4'h1
`define REG_ENABLE       4'h2
`define REG_STATE        4'h3
`define REG_CONTROL      4'h4
// Interrupt status bit positions.
`define IRQ_DONE         0
`define IRQ_ERROR        1
`define IRQ_BYTE         2
`define IRQ_WIDTH        3
`endif

// *** logic/wait_timer.v ***
// Down-counting wait timer that raises done after a loaded count.
`timescale 1ns/10ps
module wait_timer #(
   parameter WIDTH = 20
) (
   input  wire             core_clk,   // Core clock.
   input  wire             reset,      // Synchronous active-high reset.
   input  wire             start,      // Loads the count.
   input  wire [WIDTH-1:0] loadValue,  // Number of cycles to wait.
   output reg              done        // High once the count has run out.
);
   reg [WIDTH-1:0] count_q;  // Cycles remaining.
   reg             busy_q;   // Counting in progress.

   // Count down after a start and flag completion.
   always @(posedge core_clk) begin
      if (reset) begin
         count_q <= {WIDTH{1'b0}};
         busy_q  <= 1'b0;
         done    <= 1'b0;
      end else if (start) begin
         count_q <= loadValue;
         busy_q  <= 1'b1;
         done    <= 1'b0;
      end else if (busy_q) begin
         // Terminal count ends the wait.
         if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            busy_q <= 1'b0;
            done   <= 1'b1;
         end else begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // wait_timer

// *** logic/config_port.v ***
// Configuration port, init line, status pins and master address generator.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "config_port_regs.vh"

//
// Function
// [RULE_01] Low-during-config flag low until user I/O active
// [RULE_02] Init line low during power-up and clearing
// [RULE_03] External low on init line holds wait
// [RULE_04] Master modes wait extra 30 us after init
// [RULE_05] Init line low reports configuration data error
// [RULE_06] Selected only when select_low low, select_high high; daisy mode selects on select_high alone
// [RULE_07] Write strobe latches data byte when selected
// [RULE_08] Read strobe returns status on bit 7
// [RULE_09] Write wins when both strobes low
// [RULE_10] Daisy mode uses select_high as serial enable
// [RULE_11] Master parallel drives 18-bit PROM address
// [RULE_12] Extended variant adds four upper address bits
// [RULE_13] Pins become user I/O after configuration
// [RULE_14] Ready/busy tells host when next byte fits
// [RULE_15] Mode pins sampled after init goes high
// [RULE_16] Data bus driven only during a pure read
module config_port #(
   parameter EXT_VARIANT = 1,      // Nonzero on the extended address variant.
   parameter FRAME_BYTES = 16,     // Bytes that complete configuration.
   parameter BYTE_CYCLES = 4,      // Cycles the device stays busy per byte.
   parameter WAIT_CYCLES = `WAIT_CYCLES  // Master-mode extra wait.
) (
   input  wire        core_clk,           // Core clock, 250 MHz.
   input  wire        reset,              // Synchronous active-high reset.
   input  wire        powerStable,        // Supply has settled.
   input  wire [2:0]  mode_select_pins,   // Configuration mode straps.
   input  wire        initIn,             // Level seen on the init line.
   output reg         initOut,            // Value driven on the init line.
   output reg         initOe,             // Init drive enable (open drain).
   output reg         low_during_config_flag,  // Low while configuring.
   input  wire        select_low,         // Active-low chip select.
   input  wire        select_high,        // Active-high chip select.
   input  wire        write_strobe_n,     // Active-low write strobe.
   input  wire        read_strobe_n,      // Active-low read strobe.
   input  wire [7:0]  dataIn,             // Level on config_data_bus.
   output reg  [7:0]  dataOut,            // Value driven on config_data_bus.
   output reg         dataOe,             // Data bus drive enable.
   input  wire [7:0]  promData,           // Byte from the PROM.
   output reg  [17:0] prom_address,       // PROM address, low bits.
   output reg  [3:0]  prom_address_ext,   // PROM address, upper bits.
   output reg         promAddrOe,         // Address pins driven.
   output reg         ready_busy_out,     // High when a byte may be written.
   output reg         daisyEnableOut,     // Serial enable to next device.
   output reg         userIoActive,       // Pins now belong to user logic.
   output reg  [7:0]  cfgByte,            // Byte handed to the loader.
   output reg         cfgByteValid,       // One-cycle strobe with cfgByte.
   input  wire        cfgDataError,       // Loader found bad data.
   input  wire [3:0]  regAddr,            // Register address.
   input  wire [7:0]  regWdata,           // Register write data.
   input  wire        regWrite,           // Register write strobe.
   input  wire        regRead,            // Register read strobe.
   output reg  [7:0]  regRdata,           // Read data, one cycle later.
   output reg         irq                 // Level interrupt.
);
   // State codes. ST_ERROR and ST_USER hold until the next reset, and
   // that reset is how a fresh configuration attempt begins.
   localparam ST_POWER = 3'h0;  // Waiting for power.
   localparam ST_CLEAR = 3'h1;  // Clearing configuration memory.
   localparam ST_WAIT  = 3'h2;  // Waiting for init line to rise.
   localparam ST_MWAIT = 3'h3;  // Extra master-mode wait.
   localparam ST_LOAD  = 3'h4;  // Loading configuration data.
   localparam ST_ERROR = 3'h5;  // Data error reported.
   localparam ST_USER  = 3'h6;  // Configuration complete.

   reg [2:0]  state_q;      // Sequencer state.
   reg [2:0]  state_d;      // Next state.
   reg [2:0]  mode_q;       // Captured mode straps.
   reg [7:0]  clrCnt_q;     // Memory clear counter.
   reg [15:0] byteCnt_q;    // Bytes loaded so far.
   reg [7:0]  busyCnt_q;    // Remaining busy cycles after a byte.
   reg        wrPrev_q;     // Previous write strobe level, for edges.
   reg        promPhase_q;  // Alternates fetch and address step.
   reg [2:0]  irqStat_q;    // Sticky interrupt status.
   reg [2:0]  irqEn_q;      // Interrupt enables.
   reg        forceErr_q;   // Software-injected error hold.
   reg        timerStart;   // Starts the master wait.
   wire       timerDone;    // Master wait elapsed.
   reg        selected;     // Device is addressed by the host.
   reg        isMaster;     // Strapped mode fetches its own data.
   reg        byteTaken;    // A byte is accepted this cycle.
   reg [7:0]  byteValue;    // The byte accepted this cycle.
   reg [2:0]  irqSet;       // Events in this cycle.

   // Shared test of a mode code against the captured or live straps.
   // One compare keeps every mode code in the header alone.
   function isMode;
      input [2:0] cur;
      input [2:0] code;
      begin
         isMode = (cur == code);
      end
   endfunction

   // Extra wait timer for master modes. It counts core clock cycles,
   // so the span follows the clock; the default meets the least wait
   // at 250 MHz and stays well below the longest one.
   wait_timer #(
      .WIDTH (20)
   ) masterWait (
      .core_clk  (core_clk),
      .reset     (reset),
      .start     (timerStart),
      .loadValue (WAIT_CYCLES[19:0]),
      .done      (timerDone)
   );

   // Selection, write acceptance and mode class decode.
   // In daisy mode an upstream part gates select_high for us.
   always @* begin
      // The straps are captured on the edge that leaves the wait state,
      // so mode_q is still stale there; the pins are judged instead.
      isMaster = isMode(mode_select_pins, `MODE_MASTER_SER) ||
                 isMode(mode_select_pins, `MODE_MASTER_PAR);    // [RULE_15]
      // Daisy mode treats select_high as the serial enable.
      if (isMode(mode_q, `MODE_DAISY))
         selected = select_high;                                // [RULE_10]
      else
         selected = !select_low && select_high;                 // [RULE_06]
      // Only the falling edge of the write strobe counts, so a strobe
      // held low for many cycles still delivers exactly one byte.
      byteTaken = 1'b0;
      byteValue = dataIn;
      if (state_q == ST_LOAD) begin
         // The PROM gets one cycle for the address, one for its byte.
         if (isMode(mode_q, `MODE_MASTER_PAR)) begin
            byteTaken = promPhase_q;
            byteValue = promData;
         end else if (selected && !write_strobe_n && wrPrev_q) begin
            // Falling write edge latches the bus; it wins over a read.
            byteTaken = 1'b1;                                   // [RULE_07]
         end
      end
   end

   // Sequencer next state.
   always @* begin
      state_d    = state_q;
      timerStart = 1'b0;
      case (state_q)
         ST_POWER: if (powerStable) state_d = ST_CLEAR;
         ST_CLEAR: if (clrCnt_q == `CLEAR_CYCLES) state_d = ST_WAIT;
         ST_WAIT: begin
            // An outside low on the init line keeps us here.
            if (initIn) begin                                   // [RULE_03]
               if (isMaster) begin
                  state_d    = ST_MWAIT;
                  timerStart = 1'b1;                            // [RULE_04]
               end else begin
                  state_d = ST_LOAD;
               end
            end
         end
         ST_MWAIT: if (timerDone) state_d = ST_LOAD;            // [RULE_04]
         ST_LOAD: begin
            // An error stops loading at once, even mid-frame.
            if (cfgDataError || forceErr_q)
               state_d = ST_ERROR;
            else if (byteCnt_q == FRAME_BYTES[15:0])
               state_d = ST_USER;
         end
         ST_ERROR: state_d = ST_ERROR;
         ST_USER:  state_d = ST_USER;
         default:  state_d = ST_POWER;
      endcase
   end

   // Sequencer registers, counters and mode capture.
   // The clear counter runs only while the memory is being cleared.
   always @(posedge core_clk) begin
      if (reset) begin
         state_q     <= ST_POWER;
         mode_q      <= `MODE_SLAVE_SER;
         clrCnt_q    <= 8'h00;
         byteCnt_q   <= 16'h0000;
         busyCnt_q   <= 8'h00;
         wrPrev_q    <= 1'b1;
         promPhase_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         // A deselected strobe reads as high, so a select that comes
         // with the strobe already low still counts as a new write.
         wrPrev_q <= write_strobe_n || !selected;
         if (state_q == ST_CLEAR)
            clrCnt_q <= clrCnt_q + 8'h01;
         // Straps are read once, as the init line is seen high.
         if (state_q == ST_WAIT && initIn)
            mode_q <= mode_select_pins;                         // [RULE_15]
         if (byteTaken) begin
            byteCnt_q <= byteCnt_q + 16'h0001;
            // Every accepted byte restarts the busy window.
            busyCnt_q <= BYTE_CYCLES[7:0];                      // [RULE_14]
         end else if (busyCnt_q != 8'h00) begin
            busyCnt_q <= busyCnt_q - 8'h01;
         end
         if (state_q == ST_LOAD)
            promPhase_q <= !promPhase_q;
      end
   end

   // Output pins, all registered. They follow state_d, so each pin
   // moves on the same edge as the sequencer, not a cycle behind.
   always @(posedge core_clk) begin
      if (reset) begin
         initOut                <= 1'b0;
         initOe                 <= 1'b1;
         low_during_config_flag <= 1'b0;
         dataOut                <= 8'h00;
         dataOe                 <= 1'b0;
         // Both address halves start together at the first PROM byte.
         {prom_address_ext, prom_address} <= `ADDR_START;
         promAddrOe             <= 1'b0;
         ready_busy_out         <= 1'b0;
         daisyEnableOut         <= 1'b0;
         userIoActive           <= 1'b0;
         cfgByte                <= 8'h00;
         cfgByteValid           <= 1'b0;
      end else begin
         // Init is driven low through power-up, clearing and errors.
         // The line is open drain: initOe does the work, initOut is low.
         initOe  <= (state_d == ST_POWER) || (state_d == ST_CLEAR) || // [RULE_02]
                    (state_d == ST_ERROR);                      // [RULE_05]
         initOut <= 1'b0;
         low_during_config_flag <= (state_d == ST_USER);        // [RULE_01]
         userIoActive <= (state_d == ST_USER);                  // [RULE_13]
         // Ready drops in the cycle a byte is taken, so a host polling
         // the pin cannot slip a second byte into one busy window.
         ready_busy_out <= (state_d == ST_LOAD) && !byteTaken &&
                           (busyCnt_q <= 8'h01);                // [RULE_14]
         // Only a pure read turns the bus around.
         // A write in the same cycle keeps the bus an input.
         dataOe <= (state_d == ST_LOAD) && selected &&
                   !read_strobe_n && write_strobe_n;            // [RULE_16] [RULE_09]
         dataOut <= {ready_busy_out && busyCnt_q == 8'h00,
                     `STATUS_FILL};                             // [RULE_08]
         // The chain enable passes on only once this part is loaded,
         // so parts further down wait their turn.
         daisyEnableOut <= isMode(mode_q, `MODE_DAISY) &&
                           select_high && (state_d == ST_USER); // [RULE_10]
         cfgByte      <= byteValue;
         cfgByteValid <= byteTaken;
         promAddrOe   <= isMode(mode_q, `MODE_MASTER_PAR) &&
                         (state_d == ST_LOAD);                  // [RULE_11] [RULE_13]
         // Step through the PROM after each fetched byte.
         // Without the extended variant the upper bits stay at zero.
         if (byteTaken && isMode(mode_q, `MODE_MASTER_PAR)) begin
            if (EXT_VARIANT != 0)
               {prom_address_ext, prom_address} <=
                  {prom_address_ext, prom_address} + 22'h000001; // [RULE_12]
            else
               prom_address <= prom_address + 18'h00001;        // [RULE_11]
         end
      end
   end

   // Interrupt events: done, error, byte accepted.
   // Done and error are sequencer edges, so each fires at most once
   // per configuration attempt.
   always @* begin
      irqSet = 3'h0;
      irqSet[`IRQ_DONE]  = (state_d == ST_USER) && (state_q != ST_USER);
      irqSet[`IRQ_ERROR] = (state_d == ST_ERROR) && (state_q != ST_ERROR);
      irqSet[`IRQ_BYTE]  = byteTaken;
   end

   // Register bus, sticky status and interrupt output.
   always @(posedge core_clk) begin
      if (reset) begin
         irqStat_q  <= 3'h0;
         irqEn_q    <= 3'h0;
         forceErr_q <= 1'b0;
         regRdata   <= 8'h00;
         irq        <= 1'b0;
      end else begin
         // A new event wins over a clear in the same cycle.
         // No event can then be lost to a clear that raced it.
         if (regWrite && regAddr == `REG_CLEAR)
            irqStat_q <= (irqStat_q & ~regWdata[2:0]) | irqSet;
         else
            irqStat_q <= irqStat_q | irqSet;
         if (regWrite && regAddr == `REG_ENABLE)
            irqEn_q <= regWdata[2:0];
         if (regWrite && regAddr == `REG_CONTROL)
            forceErr_q <= regWdata[0];
         // This cycle's events are folded in so that irq rises with
         // the status bit rather than one cycle after it.
         irq <= |((irqStat_q | irqSet) & irqEn_q);
         // Read data stand for one cycle only; zero otherwise, so a
         // late sample never looks like a fresh answer.
         regRdata <= 8'h00;
         if (regRead) begin
            case (regAddr)
               `REG_STATUS:  regRdata <= {5'h00, irqStat_q};
               `REG_ENABLE:  regRdata <= {5'h00, irqEn_q};
               `REG_STATE:   regRdata <= {2'h0, mode_q, state_q};
               `REG_CONTROL: regRdata <= {7'h00, forceErr_q};
               default:      regRdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // config_port

// *** verif/config_port_chk.sv ***
// Checker for the configuration port pins and its bind.
`timescale 1ns/10ps
module config_port_chk (
   input wire        core_clk,
   input wire        reset,
   input wire        initOut,
   input wire        initOe,
   input wire        low_during_config_flag,
   input wire        select_low,
   input wire        select_high,
   input wire        write_strobe_n,
   input wire        read_strobe_n,
   input wire [7:0]  dataIn,
   input wire [7:0]  dataOut,
   input wire        dataOe,
   input wire [17:0] prom_address,
   input wire [3:0]  prom_address_ext,
   input wire        promAddrOe,
   input wire        ready_busy_out,
   input wire        userIoActive,
   input wire [7:0]  cfgByte,
   input wire        cfgByteValid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // Chip selected; both selects must agree at once.
   wire        sel  = !select_low && select_high;
   wire [21:0] addr = {prom_address_ext, prom_address};
   reset_init_a:
      assert property ($fell(reset) |-> initOe && !low_during_config_flag)
      else $error("Init or flag wrong at reset release.");
   flag_config_a:
      assert property (!userIoActive && !$past(userIoActive)
         |-> !low_during_config_flag) else $error("Flag high too early.");
   init_drain_a:
      assert property (initOe |-> !initOut) else $error("Init not low.");
   bus_drive_a:
      assert property (dataOe |-> $past(sel && !read_strobe_n
         && write_strobe_n)) else $error("Data bus driven unasked.");
   status_fill_a:
      assert property (dataOe |-> dataOut[6:0] == 7'h7f)
      else $error("Status fill wrong.");
   byte_take_a:
      assert property (cfgByteValid && !promAddrOe && !$past(promAddrOe)
         |-> $past(sel && !write_strobe_n) && cfgByte == $past(dataIn))
      else $error("Byte taken wrongly.");
   byte_busy_a:
      assert property (cfgByteValid && !promAddrOe |-> !ready_busy_out)
      else $error("Ready while byte in work.");
   addr_step_a:
      assert property (promAddrOe && $past(promAddrOe)
         |-> addr - $past(addr) <= 22'h000001) else $error("Address jump.");
   user_io_a:
      assert property (userIoActive && $past(userIoActive)
         |-> !promAddrOe && !dataOe) else $error("Pins kept after config.");
endmodule // config_port_chk
bind config_port config_port_chk i_chk (.core_clk(core_clk), .reset(reset),
   .initOut(initOut), .initOe(initOe), .select_low(select_low),
   .low_during_config_flag(low_during_config_flag), .dataIn(dataIn),
   .select_high(select_high), .write_strobe_n(write_strobe_n),
   .read_strobe_n(read_strobe_n), .dataOut(dataOut), .dataOe(dataOe),
   .prom_address(prom_address), .prom_address_ext(prom_address_ext),
   .promAddrOe(promAddrOe), .ready_busy_out(ready_busy_out),
   .userIoActive(userIoActive), .cfgByte(cfgByte),
   .cfgByteValid(cfgByteValid));

// *** verif/config_port_host.sv ***
// Host processor model for the asynchronous peripheral port.
`timescale 1ns/10ps
module config_port_host (
   input  wire       core_clk,
   input  wire [7:0] dataOut,
   input  wire       dataOe,
   input  wire       initOe,
   input  wire       holdInit,
   output reg        select_low,
   output reg        select_high,
   output reg        write_strobe_n,
   output reg        read_strobe_n,
   output wire [7:0] dataIn,
   output wire       initIn
);
   reg [7:0] hostData = 8'h00;  // Byte the host drives during a write.
   reg [7:0] idlePat  = 8'h5a;  // Changes each cycle so stale data shows.
   reg       driving  = 1'b0;   // Host owns the bus.
   initial begin
      select_low     = 1'b1;
      select_high    = 1'b0;
      write_strobe_n = 1'b1;
      read_strobe_n  = 1'b1;
   end
   // The bus has no pull, so an undriven bus must not look steady.
   always @(posedge core_clk) idlePat <= ~idlePat;
   assign dataIn = dataOe ? dataOut : (driving ? hostData : idlePat);
   // Pull-up on the init line; either party may pull it low.
   assign initIn = !(initOe || holdInit);
   // One-cycle write; both strobes low only when asked for.
   task write_byte(input [7:0] b, input sh, input both);
      @(posedge core_clk);
      select_low     <= 1'b0;
      select_high    <= sh;
      write_strobe_n <= 1'b0;
      read_strobe_n  <= !both;
      hostData       <= b;
      driving        <= 1'b1;
      @(posedge core_clk);
      select_low     <= 1'b1;
      select_high    <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      driving        <= 1'b0;
   endtask
   // Raise or drop select_high alone, as an upstream part would.
   task chain_enable(input e);
      @(posedge core_clk);
      select_high <= e;
   endtask
   // Status read; the device answers one cycle after the strobe.
   task read_status(output [7:0] v);
      @(posedge core_clk);
      select_low    <= 1'b0;
      select_high   <= 1'b1;
      read_strobe_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk) v = dataIn;
      @(posedge core_clk);
      select_low    <= 1'b1;
      select_high   <= 1'b0;
      read_strobe_n <= 1'b1;
   endtask
endmodule // config_port_host

// *** verif/config_port_tb_top.sv ***
// Testbench for the configuration port block.
`timescale 1ns/10ps
`include "config_port_regs.vh"
module config_port_tb_top;
   localparam FRAME = 4;
   localparam WAITC = 10;
   reg        core_clk = 1'b0, reset = 1'b1, powerStable = 1'b0;
   reg        cfgDataError = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   reg        holdInit = 1'b1;
   reg  [2:0] modeSel = 3'h5;
   reg  [3:0] regAddr = 4'h0;
   reg  [7:0] regWdata = 8'h00, promData = 8'h00, v, lastByte = 8'h00;
   wire       initIn, initOut, initOe, flag, sl, sh, ws, rs, dataOe, aoe;
   wire       rdy, daisy, uio, bValid, irq;
   wire [7:0] dIn, dOut, cfgByte, regRdata;
   wire [17:0] pa;
   wire [3:0] pax;
   integer    fail_count = 0, comparisons = 0, nBytes = 0, k, n;
   always #2 core_clk = ~core_clk;
   // Count bytes handed on and keep the last one.
   always @(posedge core_clk) if (bValid) begin
      nBytes   <= nBytes + 1;
      lastByte <= cfgByte;
   end
   // The PROM returns the low address byte as data.
   always @(posedge core_clk) promData <= pa[7:0];
   config_port #(.EXT_VARIANT(1), .FRAME_BYTES(FRAME), .BYTE_CYCLES(16),
      .WAIT_CYCLES(WAITC)) i_dut (.core_clk(core_clk), .reset(reset),
      .powerStable(powerStable), .mode_select_pins(modeSel),
      .initIn(initIn), .initOut(initOut), .initOe(initOe),
      .low_during_config_flag(flag), .select_low(sl), .select_high(sh),
      .write_strobe_n(ws), .read_strobe_n(rs), .dataIn(dIn),
      .dataOut(dOut), .dataOe(dataOe), .promData(promData),
      .prom_address(pa), .prom_address_ext(pax), .promAddrOe(aoe),
      .ready_busy_out(rdy), .daisyEnableOut(daisy), .userIoActive(uio),
      .cfgByte(cfgByte), .cfgByteValid(bValid), .cfgDataError(cfgDataError),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .irq(irq));
   config_port_host i_host (.core_clk(core_clk), .dataOut(dOut),
      .dataOe(dataOe), .initOe(initOe), .holdInit(holdInit),
      .select_low(sl), .select_high(sh), .write_strobe_n(ws),
      .read_strobe_n(rs), .dataIn(dIn), .initIn(initIn));
   task check(input [31:0] seen, input [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("Mismatches %0d of %0d compares", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task reg_wr(input [3:0] a, input [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task reg_rd(input [3:0] a);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk) v = regRdata;
   endtask
   // Bounded wait: 0 ready, 1 flag high, 2 address pins driven.
   task wait_hi(input integer w);
      n = 0;
      @(negedge core_clk);
      while (((w == 0) ? rdy : (w == 1) ? flag : aoe) !== 1'b1 && n < 3000)
      begin
         @(negedge core_clk);
         n = n + 1;
      end
      check(n < 3000, 1);
   endtask
   // Reset for 12 cycles with the init line held low from outside.
   task start_run(input [2:0] m);
      @(posedge core_clk);
      reset       <= 1'b1;
      modeSel     <= m;
      holdInit    <= 1'b1;
      powerStable <= 1'b0;
      repeat (12) @(posedge core_clk);
      reset       <= 1'b0;
      powerStable <= 1'b1;
      @(negedge core_clk);
      check(initOe, 1);
      check(flag, 0);
      repeat (300) @(posedge core_clk);
      check(aoe, 0);
      check(rdy, 0);
      check(initOe, 0);
   endtask
   initial begin
      start_run(`MODE_PERIPH_ASY);
      i_host.write_byte(8'h11, 1'b1, 1'b0);
      repeat (4) @(posedge core_clk);
      check(nBytes, 0);
      holdInit <= 1'b0;
      wait_hi(0);
      reg_wr(`REG_ENABLE, 8'h07);
      i_host.read_status(v);
      check(v, 8'hff);
      i_host.write_byte(8'h22, 1'b0, 1'b0);
      repeat (4) @(posedge core_clk);
      check(nBytes, 0);
      for (k = 0; k < FRAME; k = k + 1) begin
         i_host.write_byte(8'ha0 + k, 1'b1, k == 1);
         if (k == 0) i_host.read_status(v);
         if (k == 0) check(v, 8'h7f);
         if (k < FRAME - 1) wait_hi(0);
         else repeat (2) @(negedge core_clk);
         check(lastByte, 8'ha0 + k);
         check(nBytes, k + 1);
      end
      wait_hi(1);
      check(uio, 1);
      repeat (2) @(negedge core_clk);
      check(irq, 1);
      reg_rd(`REG_STATUS);
      check(v[`IRQ_DONE], 1);
      reg_wr(`REG_ENABLE, 8'h00);
      repeat (2) @(negedge core_clk);
      check(irq, 0);
      reg_wr(`REG_ENABLE, 8'h01);
      repeat (2) @(negedge core_clk);
      check(irq, 1);
      reg_wr(`REG_CLEAR, 8'h07);
      repeat (2) @(negedge core_clk);
      check(irq, 0);
      reg_rd(4'hf);
      check(v, 8'h00);
      start_run(`MODE_PERIPH_ASY);
      holdInit <= 1'b0;
      wait_hi(0);
      i_host.write_byte(8'h3c, 1'b1, 1'b0);
      @(posedge core_clk) cfgDataError <= 1'b1;
      repeat (4) @(negedge core_clk);
      check(initOe, 1);
      reg_rd(`REG_STATUS);
      check(v[`IRQ_ERROR], 1);
      @(posedge core_clk) cfgDataError <= 1'b0;
      start_run(`MODE_MASTER_PAR);
      holdInit <= 1'b0;
      wait_hi(2);
      check(n >= WAITC, 1);
      wait_hi(1);
      repeat (2) @(negedge core_clk);
      check(aoe, 0);
      check({pax, pa}, FRAME);
      check(lastByte, FRAME - 1);
      start_run(`MODE_DAISY);
      holdInit <= 1'b0;
      for (k = 0; k < FRAME; k = k + 1) begin
         wait_hi(0);
         i_host.write_byte(8'hc0 + k, 1'b1, 1'b0);
      end
      wait_hi(1);
      check(lastByte, 8'hc3);
      i_host.chain_enable(1'b1);
      repeat (2) @(negedge core_clk);
      check(daisy, 1);
      i_host.chain_enable(1'b0);
      repeat (2) @(negedge core_clk);
      check(daisy, 0);
      end_of_test;
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      #200000;
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule // config_port_tb_top
